// *** core/orr_ctrl.sv ***
// Output-port retry recovery controller
`timescale 1ns/1ps
`default_nettype none
module orr_ctrl
  import orr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Enables
  input wire logic train_done,
  input wire logic sw_enable,
  // Received control symbols
  input wire logic sym_valid,
  input wire logic sym_error,
  input wire logic sym_retry,
  input wire logic sym_not_acc,
  input wire orr_pkg::orr_ackid_t sym_ackid,
  input wire logic port_error,
  input wire logic ack_ok,
  // Packet launcher
  input wire logic pkt_req,
  input wire logic pkt_busy,
  output logic pkt_launch,
  output orr_pkg::orr_ackid_t pkt_ackid,
  output logic resend,
  // Status
  output logic port_enabled,
  output logic port_ready,
  output logic retry_stopped,
  output logic err_handoff,
  output orr_pkg::orr_ackid_t oldest_ackid,
  output orr_pkg::orr_state_e state
);
  orr_state_e state_r, state_nxt;
  orr_ackid_t retry_id_r;
  orr_ackid_t next_id;
  logic retry_seen, stop_done, rewind, out_err;
  logic ready_r, stopped_r, handoff_r, resend_r;

  assign port_enabled = train_done && sw_enable;
  // Only an acknowledge received without a symbol error counts
  assign retry_seen = sym_valid && !sym_error && sym_retry;
  assign out_err = port_error || (sym_valid && !sym_error && sym_not_acc);
  assign rewind = state_r == ORR_RECOVER && !out_err;

  orr_stop_timer u_timer (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .start(state_r == ORR_WAIT && state_nxt == ORR_STOP),
    .busy_in(pkt_busy),
    .done(stop_done)
  );

  orr_rewind u_rewind (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .launch(pkt_launch),
    .ack_ok(ack_ok),
    .rewind(rewind),
    .rewind_id(retry_id_r),
    .next_id(next_id),
    .oldest_id(oldest_ackid)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ORR_DISABLED: begin
        if (port_enabled) begin
          state_nxt = ORR_WAIT;
        end
      end
      ORR_WAIT: begin
        if (!port_enabled) begin
          state_nxt = ORR_DISABLED;
        end else if (retry_seen) begin
          state_nxt = ORR_STOP;
        end
      end
      ORR_STOP: begin
        if (stop_done) begin
          state_nxt = ORR_RECOVER;
        end
      end
      ORR_RECOVER: begin
        // Recovery is one cycle: rewind and restart together, except on an output error, which hands off with no rewind
        state_nxt = ORR_WAIT;
      end
      default: state_nxt = ORR_DISABLED;
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r <= ORR_DISABLED;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Partner's expected id, the packet to resend from
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      retry_id_r <= ORR_ACKID_RST;
    end else if (state_r == ORR_WAIT && retry_seen) begin
      retry_id_r <= sym_ackid;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      stopped_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (state_nxt == ORR_STOP) begin
      stopped_r <= 1'b1;
      ready_r <= 1'b0;
    end else if (rewind) begin
      stopped_r <= 1'b0;
      ready_r <= 1'b1;
    end else if (state_r == ORR_RECOVER) begin
      // Error machine owns the port now; retry machine lets go
      stopped_r <= 1'b0;
      ready_r <= 1'b0;
    end else if (state_nxt == ORR_DISABLED) begin
      ready_r <= 1'b0;
    end else if (state_r == ORR_DISABLED && port_enabled) begin
      ready_r <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      handoff_r <= 1'b0;
    end else begin
      handoff_r <= state_r == ORR_RECOVER && out_err;
    end
  end

  // Packets sent after a rewind are resends until caught up with old head
  orr_ackid_t head_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      head_r <= ORR_ACKID_RST;
      resend_r <= 1'b0;
    end else if (rewind) begin
      head_r <= next_id;
      resend_r <= next_id != retry_id_r;
    end else if (pkt_launch && orr_inc(next_id) == head_r) begin
      resend_r <= 1'b0;
    end
  end

  // No new launch while stopped or not ready
  assign pkt_launch = pkt_req && ready_r && !stopped_r
    && state_r == ORR_WAIT;
  assign pkt_ackid = next_id;
  assign resend = resend_r;
  assign port_ready = ready_r;
  assign retry_stopped = stopped_r;
  assign err_handoff = handoff_r;
  assign state = state_r;

  sequence s_retry_in;
    state_r == ORR_WAIT && port_enabled && retry_seen;
  endsequence
  sequence s_stopping;
    state_r == ORR_STOP && retry_stopped && !port_ready;
  endsequence

  a_reset_disabled: assert property (
    @(posedge clk_sys) $rose(nrst) |-> state_r == ORR_DISABLED)
    else $error("not disabled after reset");
  // Recover returns to wait unconditionally, so only entry from disabled
  a_enable_gated: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_WAIT && $past(state_r) == ORR_DISABLED
    |-> $past(port_enabled))
    else $error("waiting without enable");
  a_enable_moves: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_DISABLED && port_enabled |=> state_r == ORR_WAIT)
    else $error("enable not followed");
  a_wait_holds: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_WAIT && port_enabled && !retry_seen
    |=> state_r == ORR_WAIT)
    else $error("left wait without retry");
  a_retry_stops: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_retry_in |=> s_stopping)
    else $error("retry did not stop output");
  a_disable_back: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_WAIT && !port_enabled |=> state_r == ORR_DISABLED)
    else $error("disable ignored");
  a_no_launch_stop: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    retry_stopped |-> !pkt_launch)
    else $error("launch while stopped");
  a_stop_recover: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    s_retry_in ##1 s_stopping [*2] |-> ##[1:64] state_r == ORR_RECOVER)
    else $error("stop never completed");
  a_rewind_id: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rewind |=> pkt_ackid == $past(retry_id_r))
    else $error("resend not from retry id");
  a_restart_ready: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    rewind |=> port_ready && !retry_stopped)
    else $error("ready not restored");
  a_err_handoff: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_RECOVER && out_err |=> err_handoff && !port_ready)
    else $error("no clean handoff");
  a_back_to_wait: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    state_r == ORR_RECOVER |=> state_r == ORR_WAIT)
    else $error("recover did not return");
endmodule
`default_nettype wire

// *** core/orr_pkg.sv ***
// Shared constants and types for the output-port retry recovery block
package orr_pkg;
  localparam int ORR_ACKID_W = 3;
  localparam int ORR_DEPTH = 8;
  // Cycles the output port takes to quiesce after a retry
  localparam logic [3:0] ORR_STOP_CYC = 4'h2;
  localparam logic [ORR_ACKID_W-1:0] ORR_ACKID_RST = 3'h0;
  typedef enum logic [3:0] {
    ORR_DISABLED = 4'h1,
    ORR_WAIT     = 4'h2,
    ORR_STOP     = 4'h4,
    ORR_RECOVER  = 4'h8
  } orr_state_e;
  typedef logic [ORR_ACKID_W-1:0] orr_ackid_t;
  function automatic orr_ackid_t orr_inc(input orr_ackid_t a);
    return orr_ackid_t'(a + 1'b1);
  endfunction
endpackage

// *** core/orr_stop_timer.sv ***
// Countdown that paces the output-port stop procedure
`timescale 1ns/1ps
`default_nettype none
module orr_stop_timer
  import orr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  input wire logic start,
  input wire logic busy_in,
  output logic done
);
  logic [3:0] cnt_r;
  logic run_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 4'h0;
      run_r <= 1'b0;
    end else if (start) begin
      cnt_r <= ORR_STOP_CYC;
      run_r <= 1'b1;
    end else if (run_r && cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end else if (run_r && !busy_in) begin
      run_r <= 1'b0;
    end
  end
  // Stop completes only once no packet is still being launched
  assign done = run_r && cnt_r == 4'h0 && !busy_in;
endmodule
`default_nettype wire

// *** core/orr_rewind.sv ***
// Outstanding ackID scoreboard with rewind on retry
`timescale 1ns/1ps
`default_nettype none
module orr_rewind
  import orr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Launch and acknowledge
  input wire logic launch,
  input wire logic ack_ok,
  // Rewind
  input wire logic rewind,
  input wire orr_pkg::orr_ackid_t rewind_id,
  // State
  output orr_pkg::orr_ackid_t next_id,
  output orr_pkg::orr_ackid_t oldest_id
);
  orr_ackid_t next_r;
  orr_ackid_t old_r;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      next_r <= ORR_ACKID_RST;
    end else if (rewind) begin
      next_r <= rewind_id;
    end else if (launch) begin
      next_r <= orr_inc(next_r);
    end
  end
  // Retry id is the partner's expected id, so everything older was taken
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      old_r <= ORR_ACKID_RST;
    end else if (rewind) begin
      old_r <= rewind_id;
    end else if (ack_ok && old_r != next_r) begin
      old_r <= orr_inc(old_r);
    end
  end
  assign next_id = next_r;
  assign oldest_id = old_r;
endmodule
`default_nettype wire

// *** sim/orr_partner.sv ***
// Far-side input port model answering packets launched by the block
`timescale 1ns/1ps
`default_nettype none
module orr_partner
  import orr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Packets from the block
  input wire logic pkt_launch,
  input wire orr_pkg::orr_ackid_t pkt_ackid,
  // Bench commands
  input wire logic refuse,
  input wire logic corrupt,
  input wire logic restart,
  input wire logic nak,
  // Symbols back to the block
  output logic sym_valid,
  output logic sym_error,
  output logic sym_retry,
  output logic sym_not_acc,
  output orr_pkg::orr_ackid_t sym_ackid,
  output logic ack_ok
);
  import orr_pkg::*;
  orr_ackid_t exp_r;
  logic stopped_r;
  // Idle ackID lines toggle so a stale value is never mistaken for live
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      exp_r <= ORR_ACKID_RST;
      stopped_r <= 1'b0;
      sym_valid <= 1'b0;
      sym_error <= 1'b0;
      sym_retry <= 1'b0;
      sym_not_acc <= 1'b0;
      sym_ackid <= ORR_ACKID_RST;
      ack_ok <= 1'b0;
    end else begin
      sym_valid <= 1'b0;
      sym_error <= 1'b0;
      sym_retry <= 1'b0;
      sym_not_acc <= 1'b0;
      ack_ok <= 1'b0;
      sym_ackid <= ~sym_ackid;
      if (restart) begin
        stopped_r <= 1'b0;
      end else if (pkt_launch && !stopped_r) begin
        if (refuse) begin
          // Refused packet dropped, expected ackID kept
          sym_valid <= 1'b1;
          sym_retry <= 1'b1;
          sym_error <= corrupt;
          sym_ackid <= exp_r;
          stopped_r <= 1'b1;
        end else if (pkt_ackid == exp_r) begin
          ack_ok <= 1'b1;
          exp_r <= orr_ackid_t'(exp_r + 3'h1);
        end
      end
      // Not-accepted on demand, to land an error inside recovery
      if (nak) begin
        sym_valid <= 1'b1;
        sym_not_acc <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// *** sim/output_port_retry_recovery_tb.sv ***
// Self-checking bench for the retry recovery controller
`timescale 1ns/1ps
`default_nettype none
module output_port_retry_recovery_tb;
  import orr_pkg::*;
  logic clk_sys, nrst, train_done, sw_enable, sym_valid, sym_error;
  logic sym_retry, port_error, ack_ok, pkt_req, pkt_busy, pkt_launch;
  logic resend, port_enabled, port_ready, retry_stopped, err_handoff;
  logic refuse, corrupt, restart, launch_in_stop, nak, sym_not_acc;
  orr_ackid_t sym_ackid, pkt_ackid, oldest_ackid, acks, hd;
  orr_state_e state;
  logic [7:0] lf;
  int fails, checks_done, cyc, stop_len;
  orr_ctrl dut_u (.clk_sys(clk_sys), .nrst(nrst), .train_done(train_done),
    .sw_enable(sw_enable), .sym_valid(sym_valid), .sym_error(sym_error),
    .sym_retry(sym_retry), .sym_not_acc(sym_not_acc), .sym_ackid(sym_ackid),
    .port_error(port_error), .ack_ok(ack_ok), .pkt_req(pkt_req),
    .pkt_busy(pkt_busy), .pkt_launch(pkt_launch), .pkt_ackid(pkt_ackid),
    .resend(resend), .port_enabled(port_enabled), .port_ready(port_ready),
    .retry_stopped(retry_stopped), .err_handoff(err_handoff),
    .oldest_ackid(oldest_ackid), .state(state));
  orr_partner far_u (.clk_sys(clk_sys), .nrst(nrst), .pkt_launch(pkt_launch),
    .pkt_ackid(pkt_ackid), .refuse(refuse), .corrupt(corrupt),
    .restart(restart), .nak(nak), .sym_valid(sym_valid),
    .sym_error(sym_error), .sym_retry(sym_retry),
    .sym_not_acc(sym_not_acc), .sym_ackid(sym_ackid), .ack_ok(ack_ok));
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // Random launch demand and in-flight packets stretch the stop phase
  always @(posedge clk_sys) begin
    #2;
    lf = lfsr(lf);
    pkt_req = lf[0];
    pkt_busy = lf[1] & lf[2];
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (ack_ok === 1'b1) acks <= orr_ackid_t'(acks + 3'h1);
    if (state === ORR_STOP) stop_len <= stop_len + 1;
    if (state === ORR_WAIT) stop_len <= 0;
    if (state === ORR_STOP && pkt_launch !== 1'b0) launch_in_stop <= 1'b1;
    if (cyc == 5000) begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic step();
    @(posedge clk_sys);
    #2;
  endtask
  task automatic chk(input string nm, input logic [3:0] e,
                     input logic [3:0] g);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wait_st(input orr_state_e s);
    int n;
    n = 0;
    while (state !== s && n < 60) begin
      step();
      n++;
    end
    chk("state", s, state);
  endtask
  task automatic wait_id(input orr_ackid_t id);
    int n;
    n = 0;
    while (pkt_ackid !== id && n < 60) begin
      step();
      n++;
    end
    chk("pkt_ackid", id, pkt_ackid);
  endtask
  // Hold the refusal until the partner has answered a launch
  task automatic retry(input logic bad);
    int n;
    n = 0;
    refuse = 1'b1;
    corrupt = bad;
    while (sym_valid !== 1'b1 && n < 60) begin
      step();
      n++;
    end
    refuse = 1'b0;
    corrupt = 1'b0;
  endtask
  task automatic restart_far();
    restart = 1'b1;
    step();
    restart = 1'b0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    {nrst, train_done, sw_enable, port_error, refuse, corrupt} = 6'h00;
    {restart, pkt_req, pkt_busy, launch_in_stop, nak} = 5'h00;
    lf = 8'h58;
    acks = ORR_ACKID_RST;
    repeat (2) @(posedge clk_sys);
    #2;
    nrst = 1'b1;
    chk("state", ORR_DISABLED, state);
    chk("port_ready", 4'h0, port_ready);
    sw_enable = 1'b1;
    step();
    step();
    chk("state", ORR_DISABLED, state);
    chk("port_enabled", 4'h0, port_enabled);
    sw_enable = 1'b0;
    train_done = 1'b1;
    step();
    step();
    chk("state", ORR_DISABLED, state);
    chk("port_enabled", 4'h0, port_enabled);
    sw_enable = 1'b1;
    step();
    chk("state", ORR_WAIT, state);
    chk("port_ready", 4'h1, port_ready);
    chk("port_enabled", 4'h1, port_enabled);
    $display("test enable done");
    repeat (10) step();
    retry(1'b1);
    repeat (4) step();
    chk("state", ORR_WAIT, state);
    restart_far();
    $display("test corrupt retry done");
    repeat (2) begin
      retry(1'b0);
      step();
      chk("state", ORR_STOP, state);
      chk("retry_stopped", 4'h1, retry_stopped);
      chk("port_ready", 4'h0, port_ready);
      wait_st(ORR_RECOVER);
      chk("stop_long", 4'h1, stop_len > ORR_STOP_CYC);
      hd = pkt_ackid;
      // Far side restarts before the first resend can reach it
      restart = 1'b1;
      step();
      restart = 1'b0;
      chk("state", ORR_WAIT, state);
      chk("port_ready", 4'h1, port_ready);
      chk("retry_stopped", 4'h0, retry_stopped);
      chk("pkt_ackid", acks, pkt_ackid);
      chk("oldest_ackid", acks, oldest_ackid);
      chk("resend", hd != acks, resend);
      chk("launch_in_stop", 4'h0, launch_in_stop);
      wait_id(hd);
      chk("resend", 4'h0, resend);
      repeat (8) step();
    end
    $display("test clean retry done");
    retry(1'b0);
    wait_st(ORR_RECOVER);
    port_error = 1'b1;
    step();
    port_error = 1'b0;
    chk("err_handoff", 4'h1, err_handoff);
    chk("state", ORR_WAIT, state);
    chk("port_ready", 4'h0, port_ready);
    restart_far();
    $display("test handoff done");
    sw_enable = 1'b0;
    step();
    chk("state", ORR_DISABLED, state);
    chk("port_ready", 4'h0, port_ready);
    sw_enable = 1'b1;
    step();
    chk("state", ORR_WAIT, state);
    chk("port_ready", 4'h1, port_ready);
    retry(1'b0);
    nak = 1'b1;
    wait_st(ORR_RECOVER);
    nak = 1'b0;
    step();
    chk("err_handoff", 4'h1, err_handoff);
    chk("port_ready", 4'h0, port_ready);
    chk("retry_stopped", 4'h0, retry_stopped);
    restart_far();
    chk("err_handoff", 4'h0, err_handoff);
    $display("test not accepted handoff done");
    train_done = 1'b0;
    step();
    chk("state", ORR_DISABLED, state);
    chk("port_enabled", 4'h0, port_enabled);
    train_done = 1'b1;
    step();
    chk("state", ORR_WAIT, state);
    chk("port_ready", 4'h1, port_ready);
    sw_enable = 1'b0;
    step();
    chk("state", ORR_DISABLED, state);
    chk("port_ready", 4'h0, port_ready);
    $display("test disable done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
